// >>> src/scoc_pkg.sv
// Constants, register map and types of the storage capacitor output control block
package scoc_pkg;
	// Operating state reported by the system sequencer
	typedef enum logic [1:0] {
		SCOC_STANDBY,
		SCOC_CHARGE,
		SCOC_ACTIVE
	} scoc_state_t;

	// Register indices on the register port
	localparam logic [3:0] ADDR_STATUS     = 4'h0;
	localparam logic [3:0] ADDR_PROF_A     = 4'h7;
	localparam logic [3:0] ADDR_PROF_B     = 4'h8;
	localparam logic [3:0] ADDR_VOUT       = 4'h9;
	localparam logic [3:0] ADDR_CHG_OUT    = 4'ha;
	localparam logic [3:0] ADDR_MARGIN     = 4'hd;

	// Field positions
	localparam int STAT_RDY_BIT    = 0;
	localparam int STAT_ALARM_BIT  = 5;
	localparam int PROF_LSB        = 0;
	localparam int PROF_W          = 6;
	localparam int RSTPF_BIT       = 3;
	localparam int VFIX_LSB        = 4;
	localparam int VSET_LSB        = 0;
	localparam int LEVEL_W         = 4;
	localparam int HIZ_BIT         = 4;
	localparam int ICH_LSB         = 5;
	localparam int ICH_W           = 3;
	localparam int VMIN_LSB        = 0;
	localparam int VMIN_W          = 3;
	localparam int MARG_LSB        = 0;
	localparam int MARG_W          = 2;

	// Reset values, optimizer-off profile code, learned-target floor and profile count
	localparam logic [5:0] PROF_RESET    = 6'h01;
	localparam logic [5:0] PROF_OFF      = 6'h00;
	localparam logic [3:0] VSET_RESET    = 4'h6;
	localparam logic [3:0] VFIX_RESET    = 4'h0;
	localparam logic [1:0] MARG_RESET    = 2'h3;
	localparam logic [2:0] ICH_RESET     = 3'h0;
	localparam logic [2:0] VMIN_RESET    = 3'h0;
	localparam logic [3:0] VOPT_INIT     = 4'hf;
	localparam logic [3:0] VOPT_MIN      = 4'h0;
	localparam int         NUM_PROFILES  = 63;

	// Converter switching timing
	localparam int CLK_PERIOD_NS   = 10;
	localparam int SW_PERIOD_NS    = 1000;
	localparam int SW_PERIOD_CYC   = SW_PERIOD_NS / CLK_PERIOD_NS;
	localparam int SW_CNT_W        = 7;
	localparam logic [SW_CNT_W-1:0] SW_LAST    = SW_CNT_W'(SW_PERIOD_CYC - 1);
	localparam logic [SW_CNT_W-1:0] SW_HALF    = SW_CNT_W'(SW_PERIOD_CYC / 2);
endpackage : scoc_pkg

// >>> src/scoc_phase_gen.sv
// Fixed-frequency switching phase generator for the converter bridge
`timescale 1ns/1ps
module scoc_phase_gen
	import scoc_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic restart,
	output logic      primary_q
);
	logic [SW_CNT_W-1:0] cnt_q;

	// One full period every SW_PERIOD_CYC clocks
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (ce) begin
			if (restart || cnt_q == SW_LAST) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	// First half primary, second half secondary
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			primary_q <= 1'b0;
		end else if (ce) begin
			if (restart) begin
				primary_q <= 1'b1;
			end else if (cnt_q == SW_LAST) begin
				primary_q <= 1'b1;
			end else if (cnt_q == SW_HALF - 1'b1) begin
				primary_q <= 1'b0;
			end
		end
	end
endmodule : scoc_phase_gen

// >>> src/scoc_ctrl.sv
// Output alarm, switch routing, converter phasing and optimizer front end
`timescale 1ns/1ps
module scoc_ctrl
	import scoc_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 ce,
	input  wire scoc_pkg::scoc_state_t op_state,
	input  wire logic                 cap_above_precharge,
	input  wire logic                 out_below_target,
	input  wire logic                 cap_above_margin,
	input  wire logic                 cap_below_margin,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	input  wire logic [3:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	output logic      [7:0]           reg_rdata,
	output logic                      ready_out,
	output logic                      precharge_switch,
	output logic                      charge_side_switch,
	output logic                      bridge_switch_one,
	output logic                      bridge_switch_two,
	output logic                      bridge_switch_three,
	output logic                      bridge_switch_four,
	output logic                      perm_to_battery,
	output logic                      perm_to_regulated,
	output logic                      regulated_to_battery,
	output logic                      regulated_drive_en,
	output logic      [3:0]           vout_target,
	output logic      [3:0]           learned_charge_target,
	output logic                      optimizer_en,
	output logic      [3:0]           margin_level,
	output logic      [2:0]           charge_current_setting,
	output logic      [2:0]           vmin_setting
);
	typedef enum logic [2:0] {
		CONV_IDLE,
		CONV_BLANK,
		CONV_PRECHARGE,
		CONV_BOOST,
		CONV_BUCK
	} scoc_conv_t;

	scoc_state_t         prev_state_q;
	scoc_conv_t          conv_q;
	scoc_conv_t          conv_d;
	logic                alarm_q;
	logic [PROF_W-1:0]   prof_q;
	logic [LEVEL_W-1:0]  vfix_q;
	logic [LEVEL_W-1:0]  vset_q;
	logic                hiz_q;
	logic [ICH_W-1:0]    ich_q;
	logic [VMIN_W-1:0]   vmin_q;
	logic [MARG_W-1:0]   marg_q;
	logic [LEVEL_W-1:0]  vopt_q [1:NUM_PROFILES];
	logic                primary;
	logic                restart;
	logic                charge_entry;
	logic                active_exit;
	logic                state_change;
	logic                wr_prof_b;
	logic [LEVEL_W-1:0]  cur_vopt;

	// Registered state lags the sequencer by one edge; a mismatch marks a transition
	assign state_change = (op_state != prev_state_q);
	assign charge_entry = state_change && (op_state == SCOC_CHARGE);
	assign active_exit  = state_change && (prev_state_q == SCOC_ACTIVE);
	assign wr_prof_b    = reg_wr && (reg_addr == ADDR_PROF_B);
	assign cur_vopt     = (prof_q == PROF_OFF) ? VOPT_INIT : vopt_q[prof_q];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_state_q <= SCOC_STANDBY;
		end else if (ce) begin
			prev_state_q <= op_state;
		end
	end

	// Output alarm latch
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			alarm_q <= 1'b0;
		end else if (ce) begin
			if (op_state == SCOC_ACTIVE && out_below_target) begin
				alarm_q <= 1'b1;
			end else if (charge_entry) begin
				alarm_q <= 1'b0;
			end
		end
	end

	// Ready pin low in Standby, low on alarm
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ready_out <= 1'b0;
		end else if (ce) begin
			ready_out <= (op_state == SCOC_ACTIVE) && !alarm_q
				&& !(out_below_target);
		end
	end

	// Host-written configuration
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prof_q <= PROF_RESET;
			vfix_q <= VFIX_RESET;
			vset_q <= VSET_RESET;
			hiz_q  <= 1'b0;
			ich_q  <= ICH_RESET;
			vmin_q <= VMIN_RESET;
			marg_q <= MARG_RESET;
		end else if (ce && reg_wr) begin
			case (reg_addr)
				ADDR_PROF_A: begin
					prof_q <= reg_wdata[PROF_LSB +: PROF_W];
				end
				ADDR_PROF_B: begin
					vfix_q <= reg_wdata[VFIX_LSB +: LEVEL_W];
				end
				ADDR_VOUT: begin
					vset_q <= reg_wdata[VSET_LSB +: LEVEL_W];
				end
				ADDR_CHG_OUT: begin
					hiz_q  <= reg_wdata[HIZ_BIT];
					ich_q  <= reg_wdata[ICH_LSB +: ICH_W];
					vmin_q <= reg_wdata[VMIN_LSB +: VMIN_W];
				end
				ADDR_MARGIN: begin
					marg_q <= reg_wdata[MARG_LSB +: MARG_W];
				end
				default: begin
				end
			endcase
		end
	end

	// Register read port
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (ce && reg_rd) begin
			reg_rdata <= '0;
			case (reg_addr)
				ADDR_STATUS: begin
					reg_rdata[STAT_ALARM_BIT] <= alarm_q;
					reg_rdata[STAT_RDY_BIT]   <= ready_out;
				end
				ADDR_PROF_A: begin
					reg_rdata[PROF_LSB +: PROF_W] <= prof_q;
				end
				ADDR_PROF_B: begin
					reg_rdata[VFIX_LSB +: LEVEL_W] <= vfix_q;
				end
				ADDR_VOUT: begin
					reg_rdata[VSET_LSB +: LEVEL_W] <= vset_q;
				end
				ADDR_CHG_OUT: begin
					reg_rdata[HIZ_BIT]              <= hiz_q;
					reg_rdata[ICH_LSB +: ICH_W]     <= ich_q;
					reg_rdata[VMIN_LSB +: VMIN_W]   <= vmin_q;
				end
				ADDR_MARGIN: begin
					reg_rdata[MARG_LSB +: MARG_W] <= marg_q;
				end
				default: begin
					reg_rdata <= '0;
				end
			endcase
		end
	end

	// Learned targets, one slot per profile
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 1; i <= NUM_PROFILES; i++) begin
				vopt_q[i] <= VOPT_INIT;
			end
		end else if (ce && prof_q != PROF_OFF) begin
			if (wr_prof_b && reg_wdata[RSTPF_BIT]) begin
				vopt_q[prof_q] <= VOPT_INIT;
			end else if (active_exit) begin
				if (cap_above_margin && cur_vopt != VOPT_MIN) begin
					vopt_q[prof_q] <= cur_vopt - 1'b1;
				end else if (cap_below_margin && cur_vopt != VOPT_INIT) begin
					vopt_q[prof_q] <= cur_vopt + 1'b1;
				end
			end
		end
	end

	// Charge level and optimizer outputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			learned_charge_target <= VOPT_INIT;
			optimizer_en          <= 1'b1;
		end else if (ce) begin
			if (prof_q == PROF_OFF) begin
				learned_charge_target <= vfix_q;
				optimizer_en          <= 1'b0;
			end else begin
				learned_charge_target <= cur_vopt;
				optimizer_en          <= 1'b1;
			end
		end
	end

	// Margin and converter settings
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			margin_level           <= {{(LEVEL_W-MARG_W){1'b0}}, MARG_RESET};
			charge_current_setting <= ICH_RESET;
			vmin_setting           <= VMIN_RESET;
			vout_target            <= VSET_RESET;
		end else if (ce) begin
			margin_level           <= {{(LEVEL_W-MARG_W){1'b0}}, marg_q};
			charge_current_setting <= ich_q;
			vmin_setting           <= vmin_q;
			vout_target            <= vset_q;
		end
	end

	// Permanent supply path by state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			perm_to_battery   <= 1'b1;
			perm_to_regulated <= 1'b0;
		end else if (ce) begin
			perm_to_battery   <= (op_state != SCOC_ACTIVE);
			perm_to_regulated <= (op_state == SCOC_ACTIVE);
		end
	end

	// Regulated pin: battery tie, converter drive, or neither when floating
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			regulated_to_battery <= 1'b1;
			regulated_drive_en   <= 1'b0;
		end else if (ce) begin
			regulated_to_battery <= (op_state != SCOC_ACTIVE) && !hiz_q;
			regulated_drive_en   <= (op_state == SCOC_ACTIVE);
		end
	end

	// Converter mode selection
	always_comb begin
		conv_d = CONV_IDLE;
		case (op_state)
			SCOC_CHARGE: begin
				conv_d = cap_above_precharge ? CONV_BOOST : CONV_PRECHARGE;
			end
			SCOC_ACTIVE: begin
				conv_d = CONV_BUCK;
			end
			default: begin
				conv_d = CONV_IDLE;
			end
		endcase
	end

	// Any mode change passes through one all-open cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			conv_q <= CONV_IDLE;
		end else if (ce) begin
			if (conv_q != CONV_BLANK && conv_d != conv_q) begin
				conv_q <= CONV_BLANK;
			end else begin
				conv_q <= conv_d;
			end
		end
	end

	// Restart so every new mode opens on a full primary half
	assign restart = (conv_q == CONV_BLANK);

	scoc_phase_gen u_phase (
		.clk       (clk),
		.rst       (rst),
		.ce        (ce),
		.restart   (restart),
		.primary_q (primary)
	);

	// Bridge switch drive per mode and phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			precharge_switch    <= 1'b0;
			charge_side_switch  <= 1'b0;
			bridge_switch_one   <= 1'b0;
			bridge_switch_two   <= 1'b0;
			bridge_switch_three <= 1'b0;
			bridge_switch_four  <= 1'b0;
		end else if (ce) begin
			precharge_switch    <= 1'b0;
			charge_side_switch  <= 1'b0;
			bridge_switch_one   <= 1'b0;
			bridge_switch_two   <= 1'b0;
			bridge_switch_three <= 1'b0;
			bridge_switch_four  <= 1'b0;
			if (!state_change && conv_d == conv_q) begin
				case (conv_q)
					CONV_PRECHARGE: begin
						precharge_switch <= 1'b1;
					end
					CONV_BOOST: begin
						charge_side_switch  <= primary;
						bridge_switch_three <= primary;
						bridge_switch_two   <= !primary;
						bridge_switch_four  <= !primary;
					end
					CONV_BUCK: begin
						bridge_switch_one   <= 1'b1;
						bridge_switch_four  <= primary;
						bridge_switch_three <= !primary;
					end
					default: begin
					end
				endcase
			end
		end
	end
endmodule : scoc_ctrl

// >>> src/unused_placeholder_none.sv
// Spare design file; holds no logic

// >>> tb/scoc_ctrl_assertions.sv
// Port checker for the storage capacitor output control block
`timescale 1ns/1ps
module scoc_ctrl_chk
	import scoc_pkg::*;
(
	input wire logic                  clk,
	input wire logic                  rst,
	input wire logic                  ce,
	input wire scoc_pkg::scoc_state_t op_state,
	input wire logic                  cap_above_precharge,
	input wire logic                  out_below_target,
	input wire logic                  ready_out,
	input wire logic                  precharge_switch,
	input wire logic                  charge_side_switch,
	input wire logic                  bridge_switch_one,
	input wire logic                  bridge_switch_two,
	input wire logic                  bridge_switch_three,
	input wire logic                  bridge_switch_four,
	input wire logic                  perm_to_battery,
	input wire logic                  perm_to_regulated
);
	default clocking dcb @(posedge clk); endclocking
	default disable iff (rst);
	logic sw_any;
	assign sw_any = precharge_switch | charge_side_switch | bridge_switch_one
		| bridge_switch_two | bridge_switch_three | bridge_switch_four;
	// Length of the running boost secondary phase, in enabled cycles
	logic [7:0] sec_len_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sec_len_q <= '0;
		end else if (ce) begin
			sec_len_q <= bridge_switch_two ? sec_len_q + 1'b1 : '0;
		end
	end
	ready_standby_a: assert property (ce && op_state == SCOC_STANDBY |=> !ready_out)
		else $error("ready high in standby");
	alarm_hold_a: assert property (
		ce && op_state == SCOC_ACTIVE && out_below_target |=> !ready_out [*8])
		else $error("ready not held low after alarm");
	active_route_a: assert property (
		ce && op_state == SCOC_ACTIVE |=> perm_to_regulated && !perm_to_battery)
		else $error("permanent output not on regulated path");
	idle_route_a: assert property (
		ce && op_state != SCOC_ACTIVE |=> perm_to_battery && !perm_to_regulated)
		else $error("permanent output not on battery");
	blank_change_a: assert property (ce && $changed(op_state) |=> !sw_any)
		else $error("switch closed across state change");
	precharge_mode_a: assert property (
		(ce && op_state == SCOC_CHARGE && !cap_above_precharge) [*8] |-> precharge_switch)
		else $error("precharge switch open at low cap");
	boost_mode_a: assert property (
		(ce && op_state == SCOC_CHARGE && cap_above_precharge) [*8]
		|-> charge_side_switch ^ bridge_switch_two)
		else $error("boost not running");
	buck_mode_a: assert property (
		(ce && op_state == SCOC_ACTIVE) [*8] |-> bridge_switch_one && !precharge_switch)
		else $error("buck not running");
	boost_pair_a: assert property (
		charge_side_switch |-> bridge_switch_three && !bridge_switch_two && !bridge_switch_one)
		else $error("boost primary pair wrong");
	boost_sec_a: assert property (
		bridge_switch_two |-> bridge_switch_four && !bridge_switch_three && !bridge_switch_one)
		else $error("boost secondary pair wrong");
	buck_pair_a: assert property (bridge_switch_one |-> bridge_switch_four != bridge_switch_three)
		else $error("buck pair wrong");
	precharge_excl_a: assert property (
		precharge_switch |-> !(charge_side_switch || bridge_switch_one || bridge_switch_two))
		else $error("precharge overlaps converter");
	boost_period_a: assert property (
		$fell(bridge_switch_two) && charge_side_switch |-> sec_len_q == 8'(SW_PERIOD_CYC / 2))
		else $error("secondary phase length wrong");
endmodule : scoc_ctrl_chk
bind scoc_ctrl scoc_ctrl_chk chk (.clk, .rst, .ce, .op_state, .cap_above_precharge,
	.out_below_target, .ready_out, .precharge_switch, .charge_side_switch,
	.bridge_switch_one, .bridge_switch_two, .bridge_switch_three, .bridge_switch_four,
	.perm_to_battery, .perm_to_regulated);

// >>> tb/scoc_host.sv
// Host model driving the register port
`timescale 1ns/1ps
module scoc_host (
	input  wire logic       clk,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic [3:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
	end
	// Settings change only through this write path
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		#1;
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		@(posedge clk);
		#1;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		#1;
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		d = reg_rdata;
		@(posedge clk);
		#1;
	endtask : rd
endmodule : scoc_host

// >>> tb/tb.sv
// Self-checking bench for the storage capacitor output control block
`timescale 1ns/1ps
module tb;
	import scoc_pkg::*;
	logic        clk, rst, ce, cap_above_precharge, out_below_target;
	logic        cap_above_margin, cap_below_margin, reg_wr, reg_rd, ready_out;
	logic        precharge_switch, charge_side_switch, bridge_switch_one, bridge_switch_two;
	logic        bridge_switch_three, bridge_switch_four, perm_to_battery, perm_to_regulated;
	logic        regulated_to_battery, regulated_drive_en, optimizer_en;
	logic [3:0]  reg_addr, vout_target, learned_charge_target, margin_level;
	logic [7:0]  reg_wdata, reg_rdata, rd_val;
	logic [2:0]  charge_current_setting, vmin_setting;
	scoc_state_t op_state;
	int          err_total, checks;
	logic [3:0]  ra [7] = '{4'h0, 4'h7, 4'h8, 4'h9, 4'ha, 4'hd, 4'h3};
	logic [7:0]  rv [7] = '{8'h00, 8'h01, 8'h00, 8'h06, 8'h00, 8'h03, 8'h00};
	scoc_host host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
	scoc_ctrl DUT (.clk, .rst, .ce, .op_state, .cap_above_precharge, .out_below_target,
		.cap_above_margin, .cap_below_margin, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata, .ready_out, .precharge_switch, .charge_side_switch, .bridge_switch_one,
		.bridge_switch_two, .bridge_switch_three, .bridge_switch_four, .perm_to_battery,
		.perm_to_regulated, .regulated_to_battery, .regulated_drive_en, .vout_target,
		.learned_charge_target, .optimizer_en, .margin_level, .charge_current_setting,
		.vmin_setting);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		host.rd(a, rd_val);
		chk($sformatf("register %h", a), exp, rd_val);
	endtask : rd_chk
	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", err_total, checks);
		if (err_total == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		#1000000;
		err_total++;
		report_and_stop();
	end
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		op_state = SCOC_STANDBY;
		cap_above_precharge = 1'b0;
		out_below_target = 1'b0;
		cap_above_margin = 1'b0;
		cap_below_margin = 1'b0;
		cyc(12);
		rst = 1'b0;
		cyc(2);
		chk("optimizer_en", 8'h01, optimizer_en);
		chk("vout_target", 8'h06, vout_target);
		chk("regulated_to_battery", 8'h01, regulated_to_battery);
		chk("margin_level", 8'h03, margin_level);
		chk("learned_charge_target", 8'h0f, learned_charge_target);
		foreach (ra[i]) begin
			rd_chk(ra[i], rv[i]);
		end
		for (int m = 0; m < 4; m++) begin
			host.wr(4'hd, 8'(m));
			chk("margin_level", 8'(m), margin_level);
		end
		host.wr(4'h8, 8'h5a);
		host.wr(4'h7, 8'h00);
		chk("learned_charge_target", 8'h05, learned_charge_target);
		chk("optimizer_en", 8'h00, optimizer_en);
		rd_chk(4'h8, 8'h50);
		host.wr(4'h7, 8'h01);
		chk("learned_charge_target", 8'h0f, learned_charge_target);
		op_state = SCOC_CHARGE;
		cyc(10);
		chk("precharge_switch", 8'h01, precharge_switch);
		chk("regulated_to_battery", 8'h01, regulated_to_battery);
		chk("perm_to_battery", 8'h01, perm_to_battery);
		cap_above_precharge = 1'b1;
		cyc(230);
		chk("precharge_switch", 8'h00, precharge_switch);
		chk("charge_side_switch", 8'h01, charge_side_switch);
		chk("bridge_switch_three", 8'h01, bridge_switch_three);
		chk("bridge_switch_two", 8'h00, bridge_switch_two);
		op_state = SCOC_ACTIVE;
		cyc(10);
		chk("ready_out", 8'h01, ready_out);
		chk("regulated_drive_en", 8'h01, regulated_drive_en);
		chk("vout_target", 8'h06, vout_target);
		chk("bridge_switch_one", 8'h01, bridge_switch_one);
		chk("bridge_switch_four", 8'h01, bridge_switch_four);
		chk("bridge_switch_three", 8'h00, bridge_switch_three);
		chk("perm_to_regulated", 8'h01, perm_to_regulated);
		host.wr(4'h9, 8'h09);
		chk("vout_target", 8'h09, vout_target);
		ce = 1'b0;
		host.wr(4'h9, 8'h03);
		ce = 1'b1;
		chk("vout_target", 8'h09, vout_target);
		rd_chk(4'h9, 8'h09);
		rd_chk(4'h0, 8'h01);
		out_below_target = 1'b1;
		cyc(1);
		out_below_target = 1'b0;
		cyc(20);
		chk("ready_out", 8'h00, ready_out);
		rd_chk(4'h0, 8'h20);
		cap_above_margin = 1'b1;
		op_state = SCOC_STANDBY;
		cyc(3);
		chk("learned_charge_target", 8'h0e, learned_charge_target);
		host.wr(4'h7, 8'h3f);
		chk("learned_charge_target", 8'h0f, learned_charge_target);
		host.wr(4'h7, 8'h01);
		chk("learned_charge_target", 8'h0e, learned_charge_target);
		cap_above_margin = 1'b0;
		host.wr(4'ha, 8'hb3);
		chk("charge_current_setting", 8'h05, charge_current_setting);
		chk("regulated_to_battery", 8'h00, regulated_to_battery);
		chk("vmin_setting", 8'h03, vmin_setting);
		op_state = SCOC_CHARGE;
		cyc(10);
		rd_chk(4'h0, 8'h00);
		chk("regulated_drive_en", 8'h00, regulated_drive_en);
		op_state = SCOC_ACTIVE;
		cyc(10);
		chk("ready_out", 8'h01, ready_out);
		chk("regulated_drive_en", 8'h01, regulated_drive_en);
		cap_below_margin = 1'b1;
		op_state = SCOC_STANDBY;
		cyc(3);
		chk("learned_charge_target", 8'h0f, learned_charge_target);
		report_and_stop();
	end
endmodule : tb
